// File: sync_pattern_detector.sv
`timescale 1ns/10ps
`default_nettype none
// How it works
// R1: Gap resync bit set resets the bit PLL after the gap.
// R2: Mode bits 6:3 give correlator A wildcard tolerance.
// R3: Readjust off: polarity fixed by the matched start pattern.
// R4: Readjust on: phase realigns on chips 1001 or 0110.
// R5: Mode 00: A then B; B only counts if its length nonzero.
// R6: Mode 01: A or B matching in parallel declares detection.
// R7: Mode 10: A, then gap, then B, in sequence.
// R8: Mode 11: A or B in parallel; first bit 0 for A, 1 for B.
// R9: B length 5 bits in chips, 0 to 10h; higher values unused.
// R10: Coarse gap bits 7:3 count half bits, up to fifteen and a half.
// R11: Coarse gap holds PLL lock only in mode 10.
// R12: Fine gap bits 2:0 count sixteenth bits, up to seven.
// R13: Without resync, fine gap corrects oscillator phase after gap.
// R14: Pattern A low byte is chips 7 to 0, bit 0 least.
// R15: All configuration registers reset to 00h.
// R16: Pattern A high byte is chips 15 to 8, bit 15 most.
// R17: Correlators compare only the programmed count of recent chips.
module sync_pattern_detector (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Register port
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  // Configuration set select
  input wire logic set_b_sel_in,
  // Chip stream from front end (asynchronous)
  input wire logic chip_in,
  input wire logic chip_valid_in,
  // Detection results
  output logic detect_out,
  output logic first_bit_out,
  output logic pll_reset_out,
  output logic pll_hold_out,
  output logic [2:0] phase_corr_out,
  output logic phase_corr_out_valid,
  output logic manc_polarity_out,
  output logic phase_adjust_out
);
  import sync_pattern_pkg::*;

  // ==================================================================
  // Configuration registers
  cfg_set_t cfg_r [2];
  cfg_set_t cfg_nxt [2];
  logic [7:0] rdata_r, rdata_nxt;
  det_state_t st_r, st_nxt;

  always_comb begin
    cfg_nxt = cfg_r;
    rdata_nxt = 8'h00;
    if (wr_in) begin
      unique case (addr_in)
        MODE_A_OFS: cfg_nxt[0].mode = wdata_in;
        LEN_A_A_OFS: cfg_nxt[0].len_a = wdata_in;
        // R9 length field
        LEN_B_A_OFS: cfg_nxt[0].len_b = {3'h0, wdata_in[LEN_HI:0]};
        GAP_A_OFS: cfg_nxt[0].gap = wdata_in;
        // R14 low chips
        PAT_A_LO_A_OFS: cfg_nxt[0].pat_a[7:0] = wdata_in;
        // R16 high chips
        PAT_A_HI_A_OFS: cfg_nxt[0].pat_a[15:8] = wdata_in;
        PAT_B_LO_A_OFS: cfg_nxt[0].pat_b[7:0] = wdata_in;
        PAT_B_HI_A_OFS: cfg_nxt[0].pat_b[15:8] = wdata_in;
        MODE_B_OFS: cfg_nxt[1].mode = wdata_in;
        LEN_A_B_OFS: cfg_nxt[1].len_a = wdata_in;
        LEN_B_B_OFS: cfg_nxt[1].len_b = {3'h0, wdata_in[LEN_HI:0]};
        GAP_B_OFS: cfg_nxt[1].gap = wdata_in;
        PAT_A_LO_B_OFS: cfg_nxt[1].pat_a[7:0] = wdata_in;
        PAT_A_HI_B_OFS: cfg_nxt[1].pat_a[15:8] = wdata_in;
        PAT_B_LO_B_OFS: cfg_nxt[1].pat_b[7:0] = wdata_in;
        PAT_B_HI_B_OFS: cfg_nxt[1].pat_b[15:8] = wdata_in;
        default: ;
      endcase
    end
    if (rd_in && addr_in == STATUS_OFS) begin
      rdata_nxt = {4'h0, st_r};
    end
  end

  // R15 reset values
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cfg_r[0] <= '0;
      cfg_r[1] <= '0;
      rdata_r <= CFG_RESET;
    end else begin
      cfg_r <= cfg_nxt;
      rdata_r <= rdata_nxt;
    end
  end
  assign rdata_out = rdata_r;

  // ==================================================================
  // Active set
  cfg_set_t cfg;
  detect_mode_t mode;
  assign cfg = set_b_sel_in ? cfg_r[1] : cfg_r[0];
  assign mode = detect_mode_t'(cfg.mode[1:0]);

  // ==================================================================
  // Input synchroniser
  chip_t sync1_r, sync2_r, prev_r;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync1_r <= '0;
      sync2_r <= '0;
      prev_r <= '0;
    end else begin
      sync1_r <= '{chip_valid_in, chip_in};
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end
  logic chip_stb;
  assign chip_stb = sync2_r.valid && !prev_r.valid;

  // ==================================================================
  // Shift register and correlators
  logic [15:0] shift_r, shift_nxt;
  always_comb begin
    shift_nxt = shift_r;
    if (chip_stb) begin
      shift_nxt = {shift_r[14:0], sync2_r.chip};
    end
  end
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      shift_r <= '0;
    end else begin
      shift_r <= shift_nxt;
    end
  end

  function automatic logic [4:0] errs(input logic [15:0] s,
    input logic [15:0] p, input logic [4:0] len);
    logic [4:0] n;
    n = 5'h00;
    for (int i = 0; i < 16; i++) begin
      if (5'(i) < len && s[i] != p[i]) begin
        n = n + 5'h01;
      end
    end
    return n;
  endfunction

  logic [4:0] len_a, len_b;
  logic match_a, match_b;
  always_comb begin
    len_a = (cfg.len_a[4:0] > LEN_MAX) ? LEN_MAX : cfg.len_a[4:0];
    len_b = (cfg.len_b[4:0] > LEN_MAX) ? LEN_MAX : cfg.len_b[4:0];
    // R17 compare programmed length; R2 wildcards on A
    match_a = (len_a != 5'h00) && chip_stb &&
      (errs(shift_nxt, cfg.pat_a, len_a) <=
       {1'b0, cfg.mode[WC_HI:WC_LO]});
    match_b = (len_b != 5'h00) && chip_stb &&
      (errs(shift_nxt, cfg.pat_b, len_b) == 5'h00);
  end

  // ==================================================================
  // Detection state machine
  logic [7:0] gap_cnt_r, gap_cnt_nxt;
  logic [4:0] b_cnt_r, b_cnt_nxt;
  logic det_nxt, first_nxt, prst_nxt, hold_nxt, pcv_nxt;
  logic det_r, first_r, prst_r, hold_r, pcv_r;
  logic [7:0] sub_r, sub_nxt;

  always_comb begin
    st_nxt = st_r;
    gap_cnt_nxt = gap_cnt_r;
    b_cnt_nxt = b_cnt_r;
    sub_nxt = sub_r;
    det_nxt = 1'b0;
    first_nxt = first_r;
    prst_nxt = 1'b0;
    pcv_nxt = 1'b0;
    hold_nxt = 1'b0;
    unique case (st_r)
      ST_HUNT_A: begin
        unique case (mode)
          // R5 sequential
          MODE_SEQ: begin
            if (match_a) begin
              if (len_b == 5'h00) begin
                det_nxt = 1'b1;
                st_nxt = ST_FOUND;
              end else begin
                b_cnt_nxt = 5'h00;
                st_nxt = ST_HUNT_B;
              end
            end
          end
          // R6 either pattern
          MODE_PAR: begin
            if (match_a || match_b) begin
              det_nxt = 1'b1;
              st_nxt = ST_FOUND;
            end
          end
          // R7 A then gap
          MODE_GAP: begin
            if (match_a) begin
              gap_cnt_nxt = {3'h0, cfg.gap[CGAP_HI:CGAP_LO]};
              sub_nxt = 8'h00;
              st_nxt = ST_GAP;
            end
          end
          // R8 first bit by pattern
          MODE_EXT: begin
            if (match_a || match_b) begin
              det_nxt = 1'b1;
              first_nxt = !match_a;
              st_nxt = ST_FOUND;
            end
          end
        endcase
      end
      ST_GAP: begin
        // R11 hold PLL in gap mode
        hold_nxt = 1'b1;
        // R10 half bit steps
        if (chip_stb) begin
          if (gap_cnt_r == 8'h00) begin
            b_cnt_nxt = 5'h00;
            st_nxt = ST_HUNT_B;
            hold_nxt = 1'b0;
            // R1 resync after gap
            if (cfg.mode[RESYNC_BIT]) begin
              prst_nxt = 1'b1;
            end else begin
              // R13 fine phase correction
              pcv_nxt = 1'b1;
            end
          end else begin
            gap_cnt_nxt = gap_cnt_r - CHIPS_PER_HALF_BIT;
          end
        end
      end
      ST_HUNT_B: begin
        if (match_b && (mode != MODE_SEQ || b_cnt_r + 5'h01 >= len_b))
        begin
          det_nxt = 1'b1;
          first_nxt = 1'b0;
          st_nxt = ST_FOUND;
        end else if (chip_stb) begin
          b_cnt_nxt = b_cnt_r + 5'h01;
          if (b_cnt_r >= len_b) begin
            st_nxt = ST_HUNT_A;
          end
        end
      end
      ST_FOUND: begin
        st_nxt = ST_FOUND;
      end
      default: st_nxt = ST_HUNT_A;
    endcase
    // A write outside hunt A restarts the hunt
    if (wr_in && st_r != ST_HUNT_A) begin
      st_nxt = ST_HUNT_A;
      hold_nxt = 1'b0;
      prst_nxt = 1'b0;
      pcv_nxt = 1'b0;
      det_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_r <= ST_HUNT_A;
      gap_cnt_r <= 8'h00;
      b_cnt_r <= 5'h00;
      sub_r <= 8'h00;
      det_r <= 1'b0;
      first_r <= 1'b0;
      prst_r <= 1'b0;
      hold_r <= 1'b0;
      pcv_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      gap_cnt_r <= gap_cnt_nxt;
      b_cnt_r <= b_cnt_nxt;
      sub_r <= sub_nxt;
      det_r <= det_nxt;
      first_r <= first_nxt;
      prst_r <= prst_nxt;
      hold_r <= hold_nxt;
      pcv_r <= pcv_nxt;
    end
  end

  // ==================================================================
  // Manchester polarity
  logic pol_r, pol_nxt, padj_r, padj_nxt;
  logic [2:0] fgap_r;
  always_comb begin
    pol_nxt = pol_r;
    padj_nxt = 1'b0;
    // R3 polarity from start pattern
    if (det_nxt) begin
      pol_nxt = match_a ? cfg.pat_a[0] : cfg.pat_b[0];
    end else if (cfg.mode[MANC_BIT] && st_r == ST_FOUND && chip_stb &&
      (shift_nxt[3:0] == 4'h9 || shift_nxt[3:0] == 4'h6)) begin
      // R4 readjust on 1001 or 0110
      pol_nxt = shift_nxt[0];
      padj_nxt = 1'b1;
    end
  end
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pol_r <= 1'b0;
      padj_r <= 1'b0;
      fgap_r <= 3'h0;
    end else begin
      pol_r <= pol_nxt;
      padj_r <= padj_nxt;
      // R12 sixteenth bit steps
      fgap_r <= pcv_nxt ? cfg.gap[FGAP_HI:0] : 3'h0;
    end
  end

  assign detect_out = det_r;
  assign first_bit_out = first_r;
  assign pll_reset_out = prst_r;
  assign pll_hold_out = hold_r;
  assign phase_corr_out = fgap_r;
  assign phase_corr_out_valid = pcv_r;
  assign manc_polarity_out = pol_r;
  assign phase_adjust_out = padj_r;

  // ==================================================================
  // Assertions
  resync_pulse_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R1
    pll_reset_out |-> $past(cfg.mode[RESYNC_BIT]))
    else $error("pll reset without resync");
  fine_corr_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R13
    phase_corr_out_valid |-> !$past(cfg.mode[RESYNC_BIT]))
    else $error("phase correction with resync");
  hold_mode_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R11
    pll_hold_out |-> $past(mode) == MODE_GAP)
    else $error("pll hold outside gap mode");
  found_seq_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R5
    detect_out |=> st_r == ST_FOUND)
    else $error("detect without found state");
  ext_bit_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R8
    $rose(detect_out) && $past(mode) == MODE_EXT && $past(match_a)
    |-> !first_bit_out)
    else $error("extended first bit wrong");
  det_pulse_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R6
    detect_out |=> !detect_out)
    else $error("detect pulse longer than one cycle");
  cover_det: cover property (@(posedge clk_in) detect_out);
  cover_gap: cover property (@(posedge clk_in) pll_hold_out);
  cover_adj: cover property (@(posedge clk_in) phase_adjust_out);
endmodule
`default_nettype wire

// File: sync_pattern_pkg.sv
package sync_pattern_pkg;
  // ==================================================================
  // Register offsets
  localparam logic [7:0] MODE_A_OFS = 8'h82;
  localparam logic [7:0] LEN_A_A_OFS = 8'h83;
  localparam logic [7:0] LEN_B_A_OFS = 8'h84;
  localparam logic [7:0] GAP_A_OFS = 8'h85;
  localparam logic [7:0] PAT_A_LO_A_OFS = 8'h86;
  localparam logic [7:0] PAT_A_HI_A_OFS = 8'h87;
  localparam logic [7:0] PAT_B_LO_A_OFS = 8'h88;
  localparam logic [7:0] PAT_B_HI_A_OFS = 8'h89;
  localparam logic [7:0] MODE_B_OFS = 8'hA2;
  localparam logic [7:0] LEN_A_B_OFS = 8'hA3;
  localparam logic [7:0] LEN_B_B_OFS = 8'hA4;
  localparam logic [7:0] GAP_B_OFS = 8'hA5;
  localparam logic [7:0] PAT_A_LO_B_OFS = 8'hA6;
  localparam logic [7:0] PAT_A_HI_B_OFS = 8'hA7;
  localparam logic [7:0] PAT_B_LO_B_OFS = 8'hA8;
  localparam logic [7:0] PAT_B_HI_B_OFS = 8'hA9;
  localparam logic [7:0] STATUS_OFS = 8'hC0;
  localparam logic [7:0] CFG_RESET = 8'h00;
  // ==================================================================
  // Field positions
  localparam int RESYNC_BIT = 7;
  localparam int WC_HI = 6;
  localparam int WC_LO = 3;
  localparam int MANC_BIT = 2;
  localparam int CGAP_HI = 7;
  localparam int CGAP_LO = 3;
  localparam int FGAP_HI = 2;
  localparam int LEN_HI = 4;
  localparam logic [4:0] LEN_MAX = 5'h10;
  // ==================================================================
  // Timing
  localparam logic [7:0] CHIPS_PER_HALF_BIT = 8'h01;
  localparam logic [7:0] SUBS_PER_HALF_BIT = 8'h08;
  typedef enum logic [1:0] {
    MODE_SEQ = 2'h0,
    MODE_PAR = 2'h1,
    MODE_GAP = 2'h2,
    MODE_EXT = 2'h3
  } detect_mode_t;
  typedef enum logic [3:0] {
    ST_HUNT_A = 4'h1,
    ST_HUNT_B = 4'h2,
    ST_GAP = 4'h4,
    ST_FOUND = 4'h8
  } det_state_t;
  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] len_a;
    logic [7:0] len_b;
    logic [7:0] gap;
    logic [15:0] pat_a;
    logic [15:0] pat_b;
  } cfg_set_t;
  typedef struct packed {
    logic valid;
    logic chip;
  } chip_t;
endpackage

// File: chip_source.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Chip stream from the front end
module chip_source (
  // Clock and control
  input wire logic clk_in,
  input wire logic go_in,
  input wire logic [15:0] pat_in,
  input wire logic [4:0] len_in,
  // Chip stream
  output logic chip_out,
  output logic chip_valid_out,
  output logic busy_out
);
  int i;
  initial begin
    chip_out = 1'b0;
    chip_valid_out = 1'b0;
    busy_out = 1'b0;
    forever begin
      @(posedge clk_in);
      if (go_in) begin
        busy_out <= 1'b1;
        // oldest chip first, bit 0 last
        for (i = int'(len_in) - 1; i >= 0; i--) begin
          chip_out <= pat_in[i];
          repeat (2) @(posedge clk_in);
          chip_valid_out <= 1'b1;
          repeat (3) @(posedge clk_in);
          chip_valid_out <= 1'b0;
          // Released line shows the inverse
          chip_out <= ~pat_in[i];
          repeat (2) @(posedge clk_in);
        end
        busy_out <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// File: tb_sync_pattern_detector.sv
`timescale 1ns/10ps
`default_nettype none
module tb_sync_pattern_detector;
  import sync_pattern_pkg::*;
  typedef struct packed {
    logic set;
    logic [7:0] mode, la, lb, gap;
    logic [15:0] pa, pb;
    logic sb, bad, det, fb, hold;
  } row_t;
  // ==========================================================
  // Signals
  logic clk_in = 1'b0, rst_n_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0;
  logic [7:0] addr_in = 8'h00, wdata_in = 8'h00, rdata_out, d;
  logic set_b_sel_in = 1'b0, chip_in, chip_valid_in, go = 1'b0, busy;
  logic detect_out, first_bit_out, pll_reset_out, pll_hold_out;
  logic [2:0] phase_corr_out;
  logic phase_corr_out_valid, manc_polarity_out, phase_adjust_out;
  logic det_s, hold_s, prst_s, padj_s;
  logic clr = 1'b0;
  logic [15:0] pat;
  logic [4:0] len;
  int err_count = 0, checked = 0, cyc = 0, k;
  row_t r;
  row_t rows [10] = '{
    '{0, 8'h01, 8'h08, 8'h08, 8'h00, 16'h00A5, 16'h003C, 0, 0, 1, 0, 0},
    '{0, 8'h01, 8'h08, 8'h08, 8'h00, 16'h00A5, 16'h003C, 1, 0, 1, 0, 0},
    '{0, 8'h01, 8'h08, 8'h08, 8'h00, 16'h00A5, 16'h003C, 0, 1, 0, 0, 0},
    '{0, 8'h09, 8'h08, 8'h08, 8'h00, 16'h00A5, 16'h003C, 0, 1, 1, 0, 0},
    '{0, 8'h03, 8'h08, 8'h08, 8'h00, 16'h00A5, 16'h003C, 1, 0, 1, 1, 0},
    '{0, 8'h03, 8'h08, 8'h08, 8'h00, 16'h00A5, 16'h003C, 0, 0, 1, 0, 0},
    '{1, 8'h00, 8'h10, 8'h00, 8'h00, 16'hC3A5, 16'h0000, 0, 0, 1, 0, 0},
    '{1, 8'h00, 8'h10, 8'h00, 8'h00, 16'hC3A5, 16'h0000, 0, 1, 0, 0, 0},
    '{0, 8'h02, 8'h08, 8'h08, 8'h18, 16'h005A, 16'h0096, 0, 0, 0, 0, 1},
    '{0, 8'h00, 8'h08, 8'h08, 8'h00, 16'h005A, 16'h0096, 0, 0, 0, 0, 0}
  };
  // ==========================================================
  // Design and chip source
  sync_pattern_detector sync_pattern_detector_inst (.clk_in(clk_in),
    .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .set_b_sel_in(set_b_sel_in), .chip_in(chip_in),
    .chip_valid_in(chip_valid_in), .detect_out(detect_out),
    .first_bit_out(first_bit_out), .pll_reset_out(pll_reset_out),
    .pll_hold_out(pll_hold_out), .phase_corr_out(phase_corr_out),
    .phase_corr_out_valid(phase_corr_out_valid),
    .manc_polarity_out(manc_polarity_out),
    .phase_adjust_out(phase_adjust_out));
  chip_source chip_source_inst (.clk_in(clk_in), .go_in(go),
    .pat_in(pat), .len_in(len), .chip_out(chip_in),
    .chip_valid_out(chip_valid_in), .busy_out(busy));
  always #2 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    det_s <= !clr && (det_s | detect_out);
    hold_s <= !clr && (hold_s | pll_hold_out);
    prst_s <= !clr && (prst_s | pll_reset_out);
    padj_s <= !clr && (padj_s | phase_adjust_out);
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      end_sim();
    end
  end
  // ==========================================================
  // Tasks
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] v);
    addr_in <= a;
    wdata_in <= v;
    wr_in <= 1'b1;
    @(posedge clk_in);
  endtask
  task automatic rreg(input logic [7:0] a);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask
  task automatic do_reset();
    rst_n_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    check({detect_out, pll_hold_out, pll_reset_out}, 16'h0000);
    rreg(STATUS_OFS);
    check(d, 16'h0001);
  endtask
  task automatic end_sim();
    if (err_count == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    {det_s, hold_s, prst_s, padj_s} = 4'h0;
    pat = 16'h0000;
    len = 5'h00;
    do_reset();
    rreg(MODE_A_OFS);
    check(d, 16'h0000);
    rreg(8'h10);
    check(d, 16'h0000);
    for (k = 0; k < 10; k++) begin
      r = rows[k];
      set_b_sel_in <= r.set;
      wreg({r.set ? 4'hA : 4'h8, 4'h2}, r.mode);
      wreg({r.set ? 4'hA : 4'h8, 4'h3}, r.la);
      wreg({r.set ? 4'hA : 4'h8, 4'h4}, r.lb);
      wreg({r.set ? 4'hA : 4'h8, 4'h5}, r.gap);
      wreg({r.set ? 4'hA : 4'h8, 4'h6}, r.pa[7:0]);
      wreg({r.set ? 4'hA : 4'h8, 4'h7}, r.pa[15:8]);
      wreg({r.set ? 4'hA : 4'h8, 4'h8}, r.pb[7:0]);
      wreg({r.set ? 4'hA : 4'h8, 4'h9}, r.pb[15:8]);
      wr_in <= 1'b0;
      pat <= (r.sb ? r.pb : r.pa) ^ {15'h0000, r.bad};
      len <= r.sb ? r.lb[4:0] : r.la[4:0];
      go <= 1'b1;
      clr <= 1'b1;
      @(posedge clk_in);
      clr <= 1'b0;
      go <= 1'b0;
      @(posedge clk_in);
      while (busy) @(posedge clk_in);
      repeat (10) @(posedge clk_in);
      check(det_s, r.det);
      if (r.mode[1:0] == 2'h3) check(first_bit_out, r.fb);
      check(hold_s, r.hold);
      check(prst_s, 1'b0);
      check(padj_s, 1'b0);
    end
    do_reset();
    end_sim();
  end
endmodule
`default_nettype wire
